// [common/nco_regs.vh]
`ifndef NCO_REGS_VH
`define NCO_REGS_VH

// ----------------------------------------
// Register byte addresses (haddr[7:0])
// ----------------------------------------
`define OFS_CONTROL      8'h00
`define OFS_CLOCK_WIDTH  8'h04
`define OFS_ACC_LOW      8'h08
`define OFS_ACC_HIGH     8'h0c
`define OFS_ACC_UPPER    8'h10
`define OFS_STEP_LOW     8'h14
`define OFS_STEP_HIGH    8'h18
`define OFS_STEP_UPPER   8'h1c
`define OFS_STATUS       8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_ENABLE      7
`define CTRL_OUT_STATE   5
`define CTRL_INVERT      4
`define CTRL_PULSE_MODE  0
`define PWS_HI           7
`define PWS_LO           5
`define CKS_HI           3
`define CKS_LO           0
`define STAT_OVERFLOW    0

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define ACC_W            20
`define RST_CONTROL      8'h00
`define RST_CLOCK_WIDTH  8'h00
`define RST_ACC          20'h00000
`define RST_STEP_LOW     8'h01
`define RST_STEP_HIGH    8'h00
`define RST_STEP_UPPER   4'h0
`define RST_SHADOW       20'h00001

// ----------------------------------------
// Clock source codes
// ----------------------------------------
`define CKS_RESERVED     4'h5
`define CKS_LAST         4'ha
`define NUM_SOURCES      11

`endif

// [rtl/nco_core.v]
`timescale 1ns/1ps
`include "nco_regs.vh"

module nco_core
(
   input  wire                hclk,
   input  wire                hresetn,
   input  wire                enable,
   input  wire                tick,
   input  wire                pulse_mode,
   input  wire [2:0]          pulse_width_select,
   input  wire [`ACC_W-1:0]   step,
   input  wire [2:0]          acc_wr,
   input  wire [7:0]          acc_wdata,
   output reg  [`ACC_W-1:0]   acc,
   output reg                 raw_out,
   output reg                 overflow
);

   reg  [7:0]      span_left;
   wire [`ACC_W:0] sum = {1'b0, acc} + {1'b0, step};

   // Periods still to hold after the first one
   function [7:0] pulse_span;
      input [2:0] pws;
      begin
         pulse_span = (8'h01 << pws) - 8'h01;
      end
   endfunction

   // ----------------------------------------
   // Phase accumulator
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         acc      <= `RST_ACC;
         overflow <= 1'b0;
      end
      else
      begin
         overflow <= enable & tick & sum[`ACC_W];
         if (acc_wr != 3'b000)
         begin
            // Writes take priority over the adder; a tick in the same cycle adds nothing
            if (acc_wr[0])
               acc[7:0] <= acc_wdata;
            if (acc_wr[1])
               acc[15:8] <= acc_wdata;
            if (acc_wr[2])
               acc[19:16] <= acc_wdata[3:0];
         end
         else if (enable && tick)
            acc <= sum[`ACC_W-1:0];
      end
   end

   // ----------------------------------------
   // Output shaping
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         raw_out   <= 1'b0;
         span_left <= 8'h00;
      end
      else if (!enable)
      begin
         raw_out   <= 1'b0;
         span_left <= 8'h00;
      end
      else if (tick)
      begin
         if (sum[`ACC_W])
         begin
            if (pulse_mode)
            begin
               raw_out   <= 1'b1;
               span_left <= pulse_span(pulse_width_select);
            end
            else
               raw_out <= ~raw_out;
         end
         else if (pulse_mode)
         begin
            if (span_left != 8'h00)
               span_left <= span_left - 8'h01;
            else
               raw_out <= 1'b0;
         end
      end
   end

endmodule

// [rtl/numerically_controlled_osc.v]
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "nco_regs.vh"

// Summary of operation
// - Oscillator runs only while enable bit set
// - Control bit 5 shows present output state
// - Invert bit flips the oscillator output
// - Mode bit: pulse mode, else toggle divide-by-two
// - Pulse width field selects 1 to 128 periods
// - Width field ignored outside pulse mode
// - Four-bit field selects the input clock source
// - Accumulator read as low, high, upper nibble
// - Unused accumulator bits read as zero
// - Accumulator updates continuously, no atomic snapshot
// - Step value is upper, high, low concatenated
// - Step low byte resets to one
// - Adder uses a separate shadow step copy
// - While enabled, low byte write loads shadow on falling edge
// - Other registers reset to zero
// - Rising edge adds step; carry is overflow
// - Fixed duty mode toggles output per overflow
// - Pulse starts at overflow edge, ends after width
// - Overflow flag stays set until software clears

module numerically_controlled_osc
(
   input  wire                     hclk,
   input  wire                     hresetn,
   input  wire                     hsel,
   input  wire [31:0]              haddr,
   input  wire [1:0]               htrans,
   input  wire                     hwrite,
   input  wire [2:0]               hsize,
   input  wire [31:0]              hwdata,
   input  wire                     hready,
   output reg  [31:0]              hrdata,
   output wire                     hreadyout,
   output wire                     hresp,
   input  wire [`NUM_SOURCES-1:0]  osc_sources,
   output reg                      nco_out
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   reg                 osc_enable;
   reg                 output_invert;
   reg                 pulse_mode_select;
   reg  [2:0]          pulse_width_select;
   reg  [3:0]          clock_source_select;
   reg  [7:0]          step_low;
   reg  [7:0]          step_high;
   reg  [3:0]          step_upper;
   reg  [`ACC_W-1:0]   step_shadow;
   reg                 shadow_pend;
   reg                 overflow_flag;

   // ----------------------------------------
   // Bus state
   // ----------------------------------------
   reg                 wr_pend;
   reg                 rd_pend;
   reg  [7:0]          addr_q;
   reg  [31:0]         next_hrdata;

   // ----------------------------------------
   // Clock source path
   // ----------------------------------------
   reg  [`NUM_SOURCES-1:0] src_meta;
   reg  [`NUM_SOURCES-1:0] src_sync;
   reg                 src_level;
   reg                 src_prev;

   wire                tick_rise;
   wire                tick_fall;
   wire [`ACC_W-1:0]   step_value_logical;
   wire [`ACC_W-1:0]   phase_accumulator;
   wire                raw_out;
   wire                overflow_event;
   wire                output_state;
   wire                take;
   wire                wr;
   wire [7:0]          w8;
   wire [2:0]          acc_wr;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   function source_valid;
      input [3:0] code;
      begin
         source_valid = (code <= `CKS_LAST) && (code != `CKS_RESERVED);
      end
   endfunction

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   // Reads take one wait state so that the returned data
   // always includes a write finished just before.
   assign take      = hsel & htrans[1] & hready;
   assign hreadyout = ~rd_pend;
   assign hresp     = 1'b0;
   assign wr        = wr_pend;
   assign w8        = hwdata[7:0];

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q  <= 8'h00;
      end
      else if (take)
      begin
         wr_pend <= hwrite;
         rd_pend <= ~hwrite;
         addr_q  <= haddr[7:0];
      end
      else
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (rd_pend)
         hrdata <= next_hrdata;
   end

   // Unmapped addresses read zero
   always @*
   begin
      next_hrdata = 32'h00000000;
      case (addr_q)
         `OFS_CONTROL:
         begin
            next_hrdata[`CTRL_ENABLE]     = osc_enable;
            next_hrdata[`CTRL_OUT_STATE]  = output_state;
            next_hrdata[`CTRL_INVERT]     = output_invert;
            next_hrdata[`CTRL_PULSE_MODE] = pulse_mode_select;
         end
         `OFS_CLOCK_WIDTH:
         begin
            next_hrdata[`PWS_HI:`PWS_LO] = pulse_width_select;
            next_hrdata[`CKS_HI:`CKS_LO] = clock_source_select;
         end
         `OFS_ACC_LOW:
            next_hrdata[7:0] = phase_accumulator[7:0];
         `OFS_ACC_HIGH:
            next_hrdata[7:0] = phase_accumulator[15:8];
         `OFS_ACC_UPPER:
            next_hrdata[3:0] = phase_accumulator[19:16];
         `OFS_STEP_LOW:
            next_hrdata[7:0] = step_low;
         `OFS_STEP_HIGH:
            next_hrdata[7:0] = step_high;
         `OFS_STEP_UPPER:
            next_hrdata[3:0] = step_upper;
         `OFS_STATUS:
            next_hrdata[`STAT_OVERFLOW] = overflow_flag;
         default:
            next_hrdata = 32'h00000000;
      endcase
   end

   // ----------------------------------------
   // Control and select registers
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         osc_enable          <= 1'b0;
         output_invert       <= 1'b0;
         pulse_mode_select   <= 1'b0;
         pulse_width_select  <= 3'h0;
         clock_source_select <= 4'h0;
      end
      else if (wr)
      begin
         if (hit(addr_q, `OFS_CONTROL))
         begin
            osc_enable        <= w8[`CTRL_ENABLE];
            output_invert     <= w8[`CTRL_INVERT];
            pulse_mode_select <= w8[`CTRL_PULSE_MODE];
         end
         if (hit(addr_q, `OFS_CLOCK_WIDTH))
         begin
            pulse_width_select  <= w8[`PWS_HI:`PWS_LO];
            clock_source_select <= w8[`CKS_HI:`CKS_LO];
         end
      end
   end

   // ----------------------------------------
   // Step registers and shadow
   // ----------------------------------------
   assign step_value_logical = {step_upper, step_high, step_low};

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         step_low   <= `RST_STEP_LOW;
         step_high  <= `RST_STEP_HIGH;
         step_upper <= `RST_STEP_UPPER;
      end
      else if (wr)
      begin
         if (hit(addr_q, `OFS_STEP_LOW))
            step_low <= w8;
         if (hit(addr_q, `OFS_STEP_HIGH))
            step_high <= w8;
         if (hit(addr_q, `OFS_STEP_UPPER))
            step_upper <= w8[3:0];
      end
   end

   // A write in the same cycle as the falling edge keeps the
   // request pending, since the new byte lands only at this edge.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         step_shadow <= `RST_SHADOW;
         shadow_pend <= 1'b0;
      end
      else if (!osc_enable)
      begin
         step_shadow <= step_value_logical;
         shadow_pend <= 1'b0;
      end
      else
      begin
         if (wr && hit(addr_q, `OFS_STEP_LOW))
            shadow_pend <= 1'b1;
         else if (tick_fall)
            shadow_pend <= 1'b0;
         if (tick_fall && shadow_pend)
            step_shadow <= step_value_logical;
      end
   end

   // ----------------------------------------
   // Overflow flag
   // ----------------------------------------
   // Write one to clear; a new overflow in the same cycle wins
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         overflow_flag <= 1'b0;
      else if (overflow_event)
         overflow_flag <= 1'b1;
      else if (wr && hit(addr_q, `OFS_STATUS) && w8[`STAT_OVERFLOW])
         overflow_flag <= 1'b0;
   end

   // ----------------------------------------
   // Input clock selection
   // ----------------------------------------
   // Sources are sampled, so each must run well below hclk/2.
   // Switching source may produce one spurious edge.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         src_meta <= {`NUM_SOURCES{1'b0}};
         src_sync <= {`NUM_SOURCES{1'b0}};
         src_prev <= 1'b0;
      end
      else
      begin
         src_meta <= osc_sources;
         src_sync <= src_meta;
         src_prev <= src_level;
      end
   end

   always @*
   begin
      src_level = 1'b0;
      if (source_valid(clock_source_select))
         src_level = src_sync[clock_source_select];
   end

   assign tick_rise = src_level & ~src_prev;
   assign tick_fall = ~src_level & src_prev;

   // ----------------------------------------
   // Accumulator and output engine
   // ----------------------------------------
   assign acc_wr[0] = wr & hit(addr_q, `OFS_ACC_LOW);
   assign acc_wr[1] = wr & hit(addr_q, `OFS_ACC_HIGH);
   assign acc_wr[2] = wr & hit(addr_q, `OFS_ACC_UPPER);

   nco_core u_core
   (
      .hclk               (hclk),
      .hresetn            (hresetn),
      .enable             (osc_enable),
      .tick               (tick_rise),
      .pulse_mode         (pulse_mode_select),
      .pulse_width_select (pulse_width_select),
      .step               (step_shadow),
      .acc_wr             (acc_wr),
      .acc_wdata          (w8),
      .acc                (phase_accumulator),
      .raw_out            (raw_out),
      .overflow           (overflow_event)
   );

   // ----------------------------------------
   // Polarity stage
   // ----------------------------------------
   assign output_state = raw_out ^ output_invert;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         nco_out <= 1'b0;
      else
         nco_out <= output_state;
   end

endmodule

// [tb/nco_checker_asserts.sv]
`timescale 1ns/1ps
`include "nco_regs.vh"

// ------------------------------
// Bus and output checker
// ------------------------------
module nco_checker
(
   input wire                    hclk,
   input wire                    hresetn,
   input wire                    hsel,
   input wire [31:0]             haddr,
   input wire [1:0]              htrans,
   input wire                    hwrite,
   input wire [2:0]              hsize,
   input wire [31:0]             hwdata,
   input wire                    hready,
   input wire [31:0]             hrdata,
   input wire                    hreadyout,
   input wire                    hresp,
   input wire [`NUM_SOURCES-1:0] osc_sources,
   input wire                    nco_out
);
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   reg       wr_c;
   reg       rd_p;
   wire      tk = hsel && htrans[1] && hready;
   wire      rv = hreadyout && rd_p;
   reg       en_q;
   reg       inv_q;
   reg [7:0] ra;
   reg [3:0] qc;
   // Mirror of the control bits, so the idle output level is known
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_c <= 1'b0;
         rd_p <= 1'b0;
         en_q <= 1'b0;
         inv_q <= 1'b0;
         ra <= 8'h00;
         qc <= 4'h0;
      end
      else
      begin
         wr_c <= tk && hwrite && haddr[7:0] == `OFS_CONTROL;
         if (tk)
            rd_p <= !hwrite;
         else if (hreadyout)
            rd_p <= 1'b0;
         if (tk)
            ra <= haddr[7:0];
         if (wr_c)
            en_q <= hwdata[`CTRL_ENABLE];
         if (wr_c)
            inv_q <= hwdata[`CTRL_INVERT];
         qc <= wr_c ? 4'h0 : (qc == 4'hf ? qc : qc + 4'h1);
      end

   sequence rd_take;
      tk && !hwrite;
   endsequence
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   read_wait_a: assert property (rd_take |=> one_wait) else $error("read wait state wrong");
   write_nowait_a: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
   resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
   rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
   upper_zero_a: assert property (rv |-> hrdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   acc_nibble_a: assert property (rv && ra == `OFS_ACC_UPPER |-> hrdata[7:4] == 4'h0)
      else $error("accumulator top nibble set");
   ctrl_unused_a: assert property (rv && ra == `OFS_CONTROL |-> hrdata[6] == 1'b0 && hrdata[3:1] == 3'h0)
      else $error("control unused bits set");
   off_level_a: assert property (!en_q && qc >= 4'h4 |-> nco_out == inv_q)
      else $error("idle output level wrong");
   reset_idle_a: assert property ($rose(hresetn) |-> nco_out == 1'b0 && hreadyout)
      else $error("state after reset wrong");
endmodule

bind numerically_controlled_osc nco_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .osc_sources(osc_sources), .nco_out(nco_out));

// [tb/numerically_controlled_osc_bench.sv]
`timescale 1ns/1ps
`include "nco_regs.vh"

`define CHK(nm, e, g) \
   begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end

// ------------------------------
// Bench top
// ------------------------------
module numerically_controlled_osc_bench;
   reg                    hclk = 1'b0;
   reg                    hresetn = 1'b0;
   reg                    hsel = 1'b0;
   reg                    hwrite = 1'b0;
   reg [1:0]              htrans = 2'h0;
   reg [2:0]              hsize = 3'h2;
   reg [31:0]             haddr = 32'h0;
   reg [31:0]             hwdata = 32'h0;
   reg [`NUM_SOURCES-1:0] osc_sources = {`NUM_SOURCES{1'b0}};
   reg [3:0]              div = 4'h0;
   reg [31:0]             d;
   reg [19:0]             acc;
   reg                    ok;
   wire [31:0]            hrdata;
   wire                   hreadyout;
   wire                   hresp;
   wire                   nco_out;
   integer                error_cnt = 0;
   integer                n_checks = 0;
   integer                k;
   integer                c;

   numerically_controlled_osc dut_u
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .osc_sources(osc_sources), .nco_out(nco_out)
   );

   initial
   begin
      forever #2 hclk = ~hclk;
   end

   // Sources run with 4-cycle phases, above the synchroniser minimum
   always @(posedge hclk)
   begin
      div <= div + 4'h1;
      osc_sources <= {`NUM_SOURCES{div[2]}};
   end

   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_checks, error_cnt);
         if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   // One single transfer; read data lands in d
   task ahb(input reg wr, input reg [7:0] a, input reg [31:0] wd);
      integer t;
      begin
         t = 0;
         hsel <= 1'b1;
         htrans <= 2'h2;
         hwrite <= wr;
         haddr <= {24'h000000, a};
         do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 20);
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= wd;
         do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 40);
         d = hrdata;
         if (t >= 40)
         begin
            error_cnt++;
            final_report;
         end
      end
   endtask

   // Length in cycles of the next full stretch of nco_out at lvl
   task meas(input reg lvl, input integer e);
      integer t;
      integer n;
      begin
         t = 0;
         n = 0;
         while (nco_out === lvl && t < 6000) begin @(posedge hclk); t++; end
         while (nco_out !== lvl && t < 6000) begin @(posedge hclk); t++; end
         while (nco_out === lvl && n < 6000) begin @(posedge hclk); n++; end
         if (t >= 6000 || n >= 6000)
         begin
            error_cnt++;
            final_report;
         end
         `CHK("level time", e, n)
      end
   endtask

   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (k = 0; k < 10; k++)
      begin
         ahb(1'b0, 8'(k * 4), 32'h0);
         `CHK("reset value", (k == 5) ? 32'h1 : 32'h0, d)
      end
      ahb(1'b1, 8'h24, 32'hff);
      ahb(1'b0, 8'h24, 32'h0);
      `CHK("unmapped", 32'h0, d)
      ahb(1'b1, `OFS_CONTROL, 32'h20);
      ahb(1'b0, `OFS_CONTROL, 32'h0);
      `CHK("output state read only", 32'h0, d)
      // Every source code, reserved ones must give no ticks
      for (k = 0; k < 16; k++)
      begin
         ahb(1'b1, `OFS_CONTROL, 32'h0);
         ahb(1'b1, `OFS_ACC_LOW, 32'h0);
         ahb(1'b1, `OFS_CLOCK_WIDTH, 32'(k));
         ahb(1'b1, `OFS_CONTROL, 32'h80);
         repeat (64) @(posedge hclk);
         ahb(1'b1, `OFS_CONTROL, 32'h0);
         ahb(1'b0, `OFS_ACC_LOW, 32'h0);
         `CHK("source ticks", (k != 5 && k < 11), d != 32'h0)
      end
      c = d;
      // A live source while disabled, so a leaking adder would show
      ahb(1'b1, `OFS_CLOCK_WIDTH, 32'h0);
      repeat (40) @(posedge hclk);
      ahb(1'b0, `OFS_ACC_LOW, 32'h0);
      `CHK("frozen acc", c, d)
      // Upper and high first, low last; disabled so shadow follows at once
      ahb(1'b1, `OFS_STEP_UPPER, 32'h1);
      ahb(1'b1, `OFS_STEP_HIGH, 32'h23);
      ahb(1'b1, `OFS_STEP_LOW, 32'h45);
      ahb(1'b1, `OFS_ACC_LOW, 32'h0);
      ahb(1'b1, `OFS_ACC_HIGH, 32'h0);
      ahb(1'b1, `OFS_ACC_UPPER, 32'h0);
      ahb(1'b1, `OFS_CLOCK_WIDTH, 32'h0);
      ahb(1'b1, `OFS_CONTROL, 32'h80);
      repeat (80) @(posedge hclk);
      ahb(1'b1, `OFS_CONTROL, 32'h0);
      ahb(1'b0, `OFS_ACC_LOW, 32'h0);
      acc[7:0] = d[7:0];
      ahb(1'b0, `OFS_ACC_HIGH, 32'h0);
      acc[15:8] = d[7:0];
      ahb(1'b0, `OFS_ACC_UPPER, 32'h0);
      acc[19:16] = d[3:0];
      ok = 1'b0;
      for (k = 1; k < 15; k++)
         if (20'(k * 20'h12345) == acc)
            ok = 1'b1;
      `CHK("acc multiple of step", 1'b1, ok)
      ahb(1'b0, `OFS_STATUS, 32'h0);
      `CHK("no overflow yet", 32'h0, d)
      // Step 0x01000: overflow every 256 ticks, 2048 cycles
      ahb(1'b1, `OFS_STEP_UPPER, 32'h0);
      ahb(1'b1, `OFS_STEP_HIGH, 32'h10);
      ahb(1'b1, `OFS_STEP_LOW, 32'h0);
      ahb(1'b1, `OFS_CLOCK_WIDTH, 32'he0);
      ahb(1'b1, `OFS_CONTROL, 32'h80);
      meas(1'b1, 2048);
      ahb(1'b0, `OFS_CONTROL, 32'h0);
      `CHK("state low", 1'b0, d[5])
      meas(1'b0, 2048);
      ahb(1'b0, `OFS_CONTROL, 32'h0);
      `CHK("state high", 1'b1, d[5])
      ahb(1'b1, `OFS_CONTROL, 32'h81);
      for (k = 0; k < 8; k++)
      begin
         ahb(1'b1, `OFS_CLOCK_WIDTH, 32'(k * 32));
         meas(1'b1, 8 << k);
      end
      ahb(1'b1, `OFS_CLOCK_WIDTH, 32'h0);
      ahb(1'b1, `OFS_CONTROL, 32'h91);
      meas(1'b0, 8);
      // Running step change: shadow picks it up, period halves
      ahb(1'b1, `OFS_CONTROL, 32'h80);
      ahb(1'b1, `OFS_STEP_HIGH, 32'h20);
      ahb(1'b1, `OFS_STEP_LOW, 32'h0);
      meas(1'b1, 1024);
      ahb(1'b0, `OFS_STATUS, 32'h0);
      `CHK("overflow flag", 1'b1, d[0])
      ahb(1'b1, `OFS_CONTROL, 32'h0);
      ahb(1'b1, `OFS_STATUS, 32'h1);
      ahb(1'b0, `OFS_STATUS, 32'h0);
      `CHK("flag cleared", 1'b0, d[0])
      repeat (8) @(posedge hclk);
      `CHK("idle output", 1'b0, nco_out)
      final_report;
   end
endmodule
